// ==== verification/hbi_props.sv ====
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// Port checker for the interpolation chain.
// ============================================================
module hbi_props
  import hbi_pkg::*;
(
  input  wire logic                     clock,
  input  wire logic                     nrst,
  input  wire logic [1:0]               interp_sel,
  input  wire logic                     zero_stuff,
  input  wire logic                     unsigned_in,
  input  wire logic signed [HBI_DW-1:0] in_i,
  input  wire logic signed [HBI_DW-1:0] in_q,
  input  wire logic                     in_ready,
  input  wire logic                     out_valid,
  input  wire logic signed [HBI_DW-1:0] out_i,
  input  wire logic signed [HBI_DW-1:0] out_q
);
  // One domain, so one clock and one reset serve every check.
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  a_ready_bypass: assert property (
    interp_sel == 2'h0 |-> in_ready) else $error("ready low at 1x");
  a_bypass_copy: assert property (
    in_ready && interp_sel == 2'h0 && !unsigned_in
    |=> out_valid && out_i == $past(in_i) && out_q == $past(in_q))
    else $error("bypass output differs from input");
  a_unsigned_flip: assert property (
    in_ready && interp_sel == 2'h0 && unsigned_in |=> out_valid
    && out_i == ($past(in_i) ^ 16'sh8000)
    && out_q == ($past(in_q) ^ 16'sh8000))
    else $error("straight binary not recoded");
  a_ready_two: assert property (
    in_ready && interp_sel == 2'h1 |=> !in_ready ##1 in_ready)
    else $error("2x take spacing wrong");
  a_ready_four: assert property (
    in_ready && interp_sel == 2'h2 |=> !in_ready [*3] ##1 in_ready)
    else $error("4x take spacing wrong");
  a_ready_eight: assert property (
    in_ready && interp_sel == 2'h3 |=> !in_ready [*7] ##1 in_ready)
    else $error("8x take spacing wrong");
  a_stuff_zero: assert property (
    zero_stuff && interp_sel != 2'h0 && out_valid && out_i != 16'sh0000
    |-> ##[1:2] (out_valid && out_i == 16'sh0000))
    else $error("no stuffed zero after sample");
  a_data_hold: assert property (
    !out_valid && $past(nrst) |-> $stable(out_i) && $stable(out_q))
    else $error("output moved without strobe");
endmodule // hbi_props

bind hbi_chain hbi_props hbi_props_inst (
  .clock(clock), .nrst(nrst), .interp_sel(interp_sel),
  .zero_stuff(zero_stuff), .unsigned_in(unsigned_in), .in_i(in_i),
  .in_q(in_q), .in_ready(in_ready), .out_valid(out_valid),
  .out_i(out_i), .out_q(out_q));
`default_nettype wire

// ==== verification/hbi_src.sv ====
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// Baseband source: offers queued I/Q words to the chain.
// ============================================================
module hbi_src
  import hbi_pkg::*;
(
  input  wire logic                     clock,
  input  wire logic                     nrst,
  input  wire logic                     in_ready,
  output logic signed [HBI_DW-1:0]      in_i,
  output logic signed [HBI_DW-1:0]      in_q
);
  logic signed [HBI_DW-1:0] qi[$];  // Pending I words.
  logic signed [HBI_DW-1:0] qq[$];  // Pending Q words.
  logic                     offer;  // Ready seen before the edge.

  initial
  begin
    in_i  = '0;
    in_q  = '0;
    offer = 1'b0;
  end

  // Queue one pair for the next take edge.
  task automatic put(input logic signed [HBI_DW-1:0] i, q);
    qi.push_back(i);
    qq.push_back(q);
  endtask

  // Ready is latched at the falling edge, since the rising edge
  // also moves the chain's phase counter.
  always @(posedge clock)
    if (nrst && offer && qi.size() > 0)
    begin
      void'(qi.pop_front());
      void'(qq.pop_front());
    end

  // Off take edges the lines are inverted each cycle, so a stale word
  // only returns on every second off cycle; an empty queue offers silence.
  always @(negedge clock)
  begin
    offer = in_ready;
    if (in_ready)
    begin
      in_i <= (qi.size() > 0) ? qi[0] : '0;
      in_q <= (qq.size() > 0) ? qq[0] : '0;
    end
    else
    begin
      in_i <= ~in_i;
      in_q <= ~in_q;
    end
  end
endmodule // hbi_src
`default_nettype wire

// ==== verification/tb.sv ====
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// Bench: one reset per mode, expected stream checked in order.
// ============================================================
module tb;
  import hbi_pkg::*;
  logic                     clock = 1'b0;  // 40 MHz clock.
  logic                     nrst  = 1'b0;  // Reset, active low.
  logic [1:0]               sel   = 2'h0;  // Factor code.
  logic                     stuff = 1'b0;  // Zero stuffing.
  logic                     uns   = 1'b0;  // Straight binary input.
  logic                     sync  = 1'b1;  // Skip startup zeros.
  wire logic signed [HBI_DW-1:0] in_i, in_q;
  logic signed [HBI_DW-1:0] out_i, out_q;
  logic                     in_ready, out_valid;
  logic signed [HBI_DW-1:0] ei[$], eq[$];  // Expected pairs.
  logic [31:0]              seed = 32'h312C7648;
  int                       n_checks = 0;
  int                       n_errors = 0;
  int                       imp[$];  // Modelled impulse response.
  int o1[$] = '{8, -29, 67, -134, 244, -414, 673, -1079, 1772, -3280,
    10364};
  int o2[$] = '{19, -120, 438, -1288, 5047};
  int o3[$] = '{7, -53, 302};

  always #12.5 clock = ~clock;

  hbi_chain hbi_chain_inst (.clock(clock), .nrst(nrst),
    .interp_sel(sel), .zero_stuff(stuff), .unsigned_in(uns),
    .in_i(in_i), .in_q(in_q), .in_ready(in_ready),
    .out_valid(out_valid), .out_i(out_i), .out_q(out_q));
  hbi_src hbi_src_inst (.clock(clock), .nrst(nrst),
    .in_ready(in_ready), .in_i(in_i), .in_q(in_q));

  // Random word; bit 0 set so no sample hides among startup zeros.
  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0] | 16'h0001;
  endfunction

  task automatic chk(input string nm, input logic signed [15:0] e, g);
    n_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("mismatch %s expected %0d got %0d", nm, e, g);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Reset stands three cycles in all while the mode settles; the
  // release in drain ends the third.
  task automatic start(input logic [1:0] s, input logic z, u);
    @(negedge clock);
    {nrst, sel, stuff, uns, sync} = {1'b0, s, z, u, 1'b1};
    repeat (2) @(negedge clock);
  endtask

  // Queue a pair: the sample, then the stuffed zeros.
  task automatic send(input logic [15:0] i, q, input int f);
    hbi_src_inst.put(i, q);
    ei.push_back(uns ? i ^ 16'h8000 : i);
    eq.push_back(uns ? q ^ 16'h8000 : q);
    for (int k = 1; k < f; k++)
    begin
      ei.push_back('0);
      eq.push_back('0);
    end
  endtask

  // Zero-stuff, mirror and filter the model stream, floor-scaled
  // by the centre weight and saturated like the chain.
  task automatic stage(input int o[$], input int c);
    int h[$];
    int u[$];
    int r[$];
    int a;
    foreach (o[k]) h = {h, o[k], 0};
    h[$] = c;
    for (int k = h.size() - 2; k >= 0; k--) h.push_back(h[k]);
    foreach (imp[k]) u = {u, imp[k], 0};
    for (int n = 0; n < u.size() + h.size() - 1; n++)
    begin
      a = 0;
      foreach (h[k]) if (n >= k && n - k < u.size()) a += h[k] * u[n-k];
      a = a >>> $clog2(c);
      r.push_back(a > 32767 ? 32767 : (a < -32768 ? -32768 : a));
    end
    imp = r;
  endtask

  // Release reset, then wait a bounded time for the stream to end.
  task automatic drain(input string nm);
    @(negedge clock);
    nrst = 1'b1;
    for (int n = 0; n < 3000 && ei.size() > 0; n++) @(negedge clock);
    if (ei.size() > 0)
    begin
      n_errors++;
      $display("mismatch %s expected 0 got %0d left", nm, ei.size());
      report_and_stop();
    end
    else
      $display("test %s done", nm);
  endtask

  // Pairs are taken in order once the first nonzero output shows.
  always @(negedge clock)
    if (out_valid === 1'b1 && ei.size() > 0 && !(sync && out_i === '0))
    begin
      sync = 1'b0;
      chk("out_i", ei.pop_front(), out_i);
      chk("out_q", eq.pop_front(), out_q);
    end

  initial
  begin
    for (int u = 0; u < 2; u++)
    begin
      start(2'h0, 1'b0, u[0]);
      repeat (8) send(rnd(), rnd(), 1);
      drain("bypass");
    end
    for (int s = 1; s < 4; s++)
    begin
      start(s[1:0], 1'b1, 1'b0);
      repeat (4) send(rnd(), rnd(), 1 << s);
      drain("stuffing");
    end
    for (int s = 1; s < 4; s++)
    begin
      start(s[1:0], 1'b0, 1'b0);
      hbi_src_inst.put(16'sh4000, 16'sh4000);
      imp = '{16384};
      stage(o1, 16384);
      if (s > 1) stage(o2, 8192);
      if (s > 2) stage(o3, 512);
      while (imp[0] == 0) void'(imp.pop_front());
      while (imp[$] == 0) void'(imp.pop_back());
      foreach (imp[k]) ei.push_back(HBI_DW'(imp[k]));
      eq = ei;
      drain("impulse");
    end
    report_and_stop();
  end
endmodule // tb
`default_nettype wire

// ==== verilog/hbi_chain.sv ====
`timescale 1ns/10ps
`default_nettype none

// ============================================================
// One half-band interpolating stage for all lanes.
// ============================================================
// Each input sample yields two outputs: the filtered phase right
// away and the centre-tap phase half an input period later. The
// centre weight is a power of two, so after rescale that phase is
// just a delayed copy of the input and needs no multiplier.
module hbi_stage
  import hbi_pkg::*;
#(
  parameter int NA    = HBI_NA1,
  parameter int SHIFT = HBI_SH1,
  parameter logic signed [HBI_CW-1:0] COEF [NA/2] = '{default: '0}
)
(
  input  wire logic                     clock,
  input  wire logic                     nrst,
  input  wire logic                     in_stb,
  input  wire logic signed [HBI_DW-1:0] in_data  [HBI_LANES],
  input  wire logic [HBI_CNTW-1:0]      half,
  input  wire logic                     zstuff,
  output logic                          out_stb,
  output logic signed [HBI_DW-1:0]      out_data [HBI_LANES]
);

  logic signed [HBI_DW-1:0]   dl_ff   [HBI_LANES][NA];  // Delay lines.
  logic signed [HBI_DW-1:0]   nxt_dl  [HBI_LANES][NA];
  logic signed [HBI_DW-1:0]   sh      [HBI_LANES][NA];  // Shifted view.
  logic [HBI_CNTW-1:0]        wait_ff;                  // Cycles to B.
  logic [HBI_CNTW-1:0]        nxt_wait;
  logic                       stb_ff;                   // Output strobe.
  logic                       nxt_stb;
  logic signed [HBI_DW-1:0]   od_ff   [HBI_LANES];      // Output data.
  logic signed [HBI_DW-1:0]   nxt_od  [HBI_LANES];
  logic signed [HBI_ACCW-1:0] acc     [HBI_LANES];      // Filter sums.
  logic signed [HBI_ACCW-1:0] scl     [HBI_LANES];      // Rescaled sums.
  logic signed [HBI_DW-1:0]   sat     [HBI_LANES];      // Clamped sums.

  // ==========================================================
  // Filter arithmetic and next-state decisions.
  // ==========================================================
  // Symmetric pairs are added before the multiply, which halves
  // the multipliers and forces a linear phase response.
  always_comb
  begin
    for (int l = 0; l < HBI_LANES; l++)
    begin
      sh[l][0] = in_data[l];
      for (int k = 1; k < NA; k++)
        sh[l][k] = dl_ff[l][k-1];
      acc[l] = '0;
      for (int k = 0; k < NA/2; k++)
        acc[l] = acc[l] + HBI_ACCW'(COEF[k]) *
                 (HBI_ACCW'(sh[l][k]) + HBI_ACCW'(sh[l][NA-1-k]));
      scl[l] = acc[l] >>> SHIFT;
      // Clamp rather than wrap, since overshoot of a full-scale
      // step would otherwise fold into a huge opposite spike.
      if (scl[l] > HBI_ACCW'(HBI_DMAX))
        sat[l] = HBI_DMAX;
      else if (scl[l] < HBI_ACCW'(HBI_DMIN))
        sat[l] = HBI_DMIN;
      else
        sat[l] = scl[l][HBI_DW-1:0];
      // Shift only on a take, so the history stays at input rate.
      if (in_stb)
        nxt_dl[l] = sh[l];
      else
        nxt_dl[l] = dl_ff[l];
    end
    nxt_wait = wait_ff;
    nxt_stb  = 1'b0;
    nxt_od   = od_ff;
    if (in_stb)
    begin
      // Filtered phase; zero stuffing passes the input instead.
      nxt_wait = half;
      nxt_stb  = 1'b1;
      for (int l = 0; l < HBI_LANES; l++)
        nxt_od[l] = zstuff ? in_data[l] : sat[l];
    end
    else if (wait_ff != '0)
    begin
      nxt_wait = wait_ff - 1'b1;
      if (wait_ff == HBI_CNTW'(1))
      begin
        // Centre phase: the delayed sample, or a stuffed zero.
        nxt_stb = 1'b1;
        for (int l = 0; l < HBI_LANES; l++)
          nxt_od[l] = zstuff ? '0 : dl_ff[l][NA/2-1];
      end
    end
  end

  // ==========================================================
  // State registers.
  // ==========================================================
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      dl_ff   <= '{default: '{default: '0}};
      wait_ff <= '0;
      stb_ff  <= 1'b0;
      od_ff   <= '{default: '0};
    end
    else
    begin
      dl_ff   <= nxt_dl;
      wait_ff <= nxt_wait;
      stb_ff  <= nxt_stb;
      od_ff   <= nxt_od;
    end
  end

  assign out_stb  = stb_ff;
  assign out_data = od_ff;

endmodule // hbi_stage

// ============================================================
// Top: input capture, stage cascade and output selection.
// ============================================================
module hbi_chain
  import hbi_pkg::*;
(
  input  wire logic                     clock,
  input  wire logic                     nrst,
  input  wire logic [1:0]               interp_sel,
  input  wire logic                     zero_stuff,
  input  wire logic                     unsigned_in,
  input  wire logic signed [HBI_DW-1:0] in_i,
  input  wire logic signed [HBI_DW-1:0] in_q,
  output logic                          in_ready,
  output logic                          out_valid,
  output logic signed [HBI_DW-1:0]      out_i,
  output logic signed [HBI_DW-1:0]      out_q
);

  hbi_rate_type             rate;                        // Factor code.
  logic [HBI_CNTW:0]        per;                         // Input period.
  logic [HBI_CNTW-1:0]      cnt_ff;                      // Phase counter.
  logic [HBI_CNTW-1:0]      nxt_cnt;
  logic                     take;                        // Input taken.
  logic                     st_stb  [HBI_NSTG+1];        // Stage strobes.
  logic signed [HBI_DW-1:0] st_d    [HBI_NSTG+1][HBI_LANES];
  logic                     ov_ff;                       // Output valid.
  logic                     nxt_ov;
  logic signed [HBI_DW-1:0] oi_ff;                       // Output I.
  logic signed [HBI_DW-1:0] oq_ff;                       // Output Q.
  logic signed [HBI_DW-1:0] nxt_oi;
  logic signed [HBI_DW-1:0] nxt_oq;

  assign rate = hbi_rate_type'(interp_sel);

  // ==========================================================
  // Input pacing and coding.
  // ==========================================================
  // One input every factor clocks, so the output runs at the full
  // clock rate. Changing the factor mid-stream is not glitch free;
  // software should hold the block in reset while reprogramming.
  always_comb
  begin
    per  = (HBI_CNTW+1)'(1) << rate;
    take = (cnt_ff == '0);
    // Wrap one short of the factor, which also pins 1x at zero.
    if (cnt_ff == HBI_CNTW'(per - 1'b1))
      nxt_cnt = '0;
    else
      nxt_cnt = HBI_CNTW'(cnt_ff + 1'b1);
  end

  // Straight binary becomes two's complement by flipping the MSB.
  assign st_d[0][0] = unsigned_in ? {~in_i[HBI_DW-1], in_i[HBI_DW-2:0]}
                                  : in_i;
  assign st_d[0][1] = unsigned_in ? {~in_q[HBI_DW-1], in_q[HBI_DW-2:0]}
                                  : in_q;
  assign st_stb[0]  = take && (rate != HBI_X1);

  always_ff @(posedge clock)
  begin
    if (!nrst)
      cnt_ff <= '0;
    else
      cnt_ff <= nxt_cnt;
  end

  assign in_ready = take;

  // ==========================================================
  // Stage cascade: long filter first, where its sharp edge is
  // cheapest to run at the lowest rate.
  // ==========================================================
  logic s2_in;  // Second stage enabled at four or eight.
  logic s3_in;  // Third stage enabled at eight only.
  assign s2_in = st_stb[1] && (rate >= HBI_X4);
  assign s3_in = st_stb[2] && (rate == HBI_X8);

  hbi_stage #(.NA(HBI_NA1), .SHIFT(HBI_SH1), .COEF(HBI_COEF1)) u_st1
  (
    .clock    (clock),
    .nrst     (nrst),
    .in_stb   (st_stb[0]),
    .in_data  (st_d[0]),
    .half     (HBI_CNTW'(per >> 1)),
    .zstuff   (zero_stuff),
    .out_stb  (st_stb[1]),
    .out_data (st_d[1])
  );

  hbi_stage #(.NA(HBI_NA2), .SHIFT(HBI_SH2), .COEF(HBI_COEF2)) u_st2
  (
    .clock    (clock),
    .nrst     (nrst),
    .in_stb   (s2_in),
    .in_data  (st_d[1]),
    .half     (HBI_CNTW'(per >> 2)),
    .zstuff   (zero_stuff),
    .out_stb  (st_stb[2]),
    .out_data (st_d[2])
  );

  hbi_stage #(.NA(HBI_NA3), .SHIFT(HBI_SH3), .COEF(HBI_COEF3)) u_st3
  (
    .clock    (clock),
    .nrst     (nrst),
    .in_stb   (s3_in),
    .in_data  (st_d[2]),
    .half     (HBI_CNTW'(per >> 3)),
    .zstuff   (zero_stuff),
    .out_stb  (st_stb[3]),
    .out_data (st_d[3])
  );

  // ==========================================================
  // Output selection: the last enabled stage, or the coded input
  // in bypass.
  // ==========================================================
  always_comb
  begin
    case (rate)
      HBI_X2:
      begin
        nxt_ov = st_stb[1];
        nxt_oi = st_d[1][0];
        nxt_oq = st_d[1][1];
      end
      HBI_X4:
      begin
        nxt_ov = st_stb[2];
        nxt_oi = st_d[2][0];
        nxt_oq = st_d[2][1];
      end
      HBI_X8:
      begin
        nxt_ov = st_stb[3];
        nxt_oi = st_d[3][0];
        nxt_oq = st_d[3][1];
      end
      default:
      begin
        nxt_ov = take;
        nxt_oi = st_d[0][0];
        nxt_oq = st_d[0][1];
      end
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      ov_ff <= 1'b0;
      oi_ff <= '0;
      oq_ff <= '0;
    end
    else
    begin
      ov_ff <= nxt_ov;
      oi_ff <= nxt_oi;
      oq_ff <= nxt_oq;
    end
  end

  assign out_valid = ov_ff;
  assign out_i     = oi_ff;
  assign out_q     = oq_ff;

endmodule // hbi_chain

`default_nettype wire

// ==== verilog/hbi_pkg.sv ====
`default_nettype none
package hbi_pkg;

  // ==========================================================
  // Data path widths.
  // ==========================================================
  localparam int HBI_DW    = 16;  // Sample width.
  localparam int HBI_CW    = 16;  // Coefficient width.
  localparam int HBI_ACCW  = 40;  // Accumulator width, wide enough for sums.
  localparam int HBI_LANES = 2;   // I and Q lanes.
  localparam int HBI_NSTG  = 3;   // Number of cascaded stages.
  localparam int HBI_CNTW  = 3;   // Width of the output phase counter.

  // Saturation bounds of the sample word.
  localparam logic signed [HBI_DW-1:0] HBI_DMAX = 16'sh7FFF;
  localparam logic signed [HBI_DW-1:0] HBI_DMIN = 16'sh8000;

  // ==========================================================
  // Interpolation factor codes.
  // ==========================================================
  typedef enum logic [1:0] {
    HBI_X1,
    HBI_X2,
    HBI_X4,
    HBI_X8
  } hbi_rate_type;

  // ==========================================================
  // Stage geometry: nonzero delay taps, rescale shift, outer
  // weights listed from the outside toward the centre.
  // ==========================================================
  localparam int HBI_NA1 = 22;  // 43 taps, 22 nonzero outer taps.
  localparam int HBI_SH1 = 14;  // Centre 16384 is two to the 14th.
  localparam logic signed [HBI_CW-1:0] HBI_COEF1 [HBI_NA1/2] = '{
    16'sh0008, -16'sh001D, 16'sh0043, -16'sh0086, 16'sh00F4,
    -16'sh019E, 16'sh02A1, -16'sh0437, 16'sh06EC, -16'sh0CD0,
    16'sh287C};
  localparam int HBI_NA2 = 10;  // 19 taps, 10 nonzero outer taps.
  localparam int HBI_SH2 = 13;  // Centre 8192 is two to the 13th.
  localparam logic signed [HBI_CW-1:0] HBI_COEF2 [HBI_NA2/2] = '{
    16'sh0013, -16'sh0078, 16'sh01B6, -16'sh0508, 16'sh13B7};
  localparam int HBI_NA3 = 6;   // 11 taps, 6 nonzero outer taps.
  localparam int HBI_SH3 = 9;   // Centre 512 is two to the 9th.
  localparam logic signed [HBI_CW-1:0] HBI_COEF3 [HBI_NA3/2] = '{
    16'sh0007, -16'sh0035, 16'sh012E};

endpackage
`default_nettype wire
